// ==== hw/rhb_builder.sv ====
/*
  Record header builder: tracks one record from start to end, collects
  range, fill and loss conditions, then streams the 40-byte header out one
  byte per cycle with valid/ready. Assumes inputs synchronous to clk and an
  acquisition engine that frames each record with start and end pulses.
  The engine must not start a new record until busy has fallen, and the
  FIFO depth input must be nonzero for the fill estimate to mean anything.
*/
`timescale 1ns/10ps
`include "rhb_regs.svh"

module rhb_builder
  import rhb_pkg::*;
#(
  parameter int FILL_W = 16
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Register port
  input  wire logic [3:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  // Acquisition engine
  input  wire logic             rec_start,
  input  wire rhb_rec_t         rec_info,
  input  wire logic             rec_end,
  input  wire rhb_loss_t        rec_loss,
  input  wire logic             range_flag,
  input  wire logic [FILL_W-1:0] fifo_level,
  input  wire logic [FILL_W-1:0] fifo_depth,
  input  wire logic             ts_reset,
  // Header byte stream
  output logic [7:0]            hdr_data,
  output logic                  hdr_valid,
  output logic                  hdr_last,
  input  wire logic             hdr_ready,
  output logic                  busy
);

  // The fill scaling shifts the level up by three bits and multiplies the
  // depth by at most seven; counters narrower than this are not worth the
  // logic, so they are refused when the design is elaborated.
  if (FILL_W < 4)
  begin : g_fill_w_check
    $error("FILL_W must be at least 4");
  end

  // Sequencer state and the byte pointer into the header.
  rhb_state_t        state_q;
  logic [5:0]        idx_q;
  logic              last_byte;
  // Settings written by software over the register port.
  logic [7:0]        user_id_q;
  logic              fmt32_q;
  logic              uhe_q;
  logic [31:0]       serial_q;
  logic [31:0]       period_q;
  logic [15:0]       gp_vec_q;
  // Counters kept across records rather than reloaded at each start.
  logic [31:0]       rec_num_q;
  logic [15:0]       ts_resets_q;
  // Conditions gathered while a record is being captured.
  rhb_rec_t          rec_q;
  logic              range_q;
  logic [2:0]        fill_q;
  logic [2:0]        fill_d;
  logic [7:0]        status_d;
  // Header snapshot and its flat view for the byte mux.
  rhb_hdr_t          hdr_q;
  logic [319:0]      hdr_bits;

  // Fill level in eighths: largest k with level*8 >= depth*k, so 000 means
  // under one eighth and 111 means seven eighths or more.
  // Both sides are widened to the same size first so that neither the
  // shifted level nor the scaled depth can overflow. A zero depth reads as
  // a full FIFO, which errs on the safe side for a flow-tuning hint.
  always_comb
  begin
    logic [FILL_W+3:0] lvl8;
    logic [FILL_W+3:0] dep;
    lvl8   = {1'b0, fifo_level, 3'h0};
    dep    = {4'h0, fifo_depth};
    fill_d = 3'h0;
    for (int k = 1; k < 8; k++)
    begin
      if (lvl8 >= dep * (FILL_W + 4)'(k))
      begin
        fill_d = 3'(k);
      end
    end
  end

  // Status byte assembled from the conditions gathered over the record.
  // The range and fill terms fold in this cycle's inputs as well, so the
  // conditions seen on the end edge itself still reach the header; the
  // loss bits are passed through as the engine reports them at the end.
  // Only the value present on the end edge is kept.
  always_comb
  begin
    status_d = 8'h00;
    status_d[`RHB_ST_RANGE_BIT] = range_q | range_flag;
    status_d[`RHB_ST_FILL_HI:`RHB_ST_FILL_LO] =
      (fill_d > fill_q) ? fill_d : fill_q;
    status_d[`RHB_ST_LOST_ALL] = rec_loss.lost_all;
    status_d[`RHB_ST_LOST_BEG] = rec_loss.lost_beg;
    status_d[`RHB_ST_LOST_MID] = rec_loss.lost_mid;
    status_d[`RHB_ST_LOST_END] = rec_loss.lost_end;
  end

  // Software settings written over the register port.
  // Writes to read-only or unmapped offsets fall through the default and
  // are ignored, so a stray write cannot disturb the record count or the
  // last status that software may still be reading.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      user_id_q <= `RHB_RST_USER_ID;
      fmt32_q   <= 1'b0;
      uhe_q     <= 1'b0;
      serial_q  <= `RHB_RST_SERIAL;
      period_q  <= `RHB_RST_PERIOD;
      gp_vec_q  <= 16'h0000;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `RHB_OFS_CTRL:
        begin
          fmt32_q <= reg_wdata[`RHB_CTRL_FMT_BIT];
          uhe_q   <= reg_wdata[`RHB_CTRL_UHE_BIT];
        end
        `RHB_OFS_USER_ID: user_id_q <= reg_wdata[7:0];
        `RHB_OFS_SERIAL:  serial_q  <= reg_wdata;
        `RHB_OFS_PERIOD:  period_q  <= reg_wdata;
        `RHB_OFS_GP_VEC:  gp_vec_q  <= reg_wdata[15:0];
        default:          ;
      endcase
    end
  end

  // Read data stands the cycle after the strobe; unmapped reads give zero.
  // Returning zero outside that cycle keeps an idle bus easy to check.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `RHB_OFS_CTRL:      reg_rdata <= {30'h0, uhe_q, fmt32_q};
        `RHB_OFS_USER_ID:   reg_rdata <= {24'h0, user_id_q};
        `RHB_OFS_SERIAL:    reg_rdata <= serial_q;
        `RHB_OFS_PERIOD:    reg_rdata <= period_q;
        `RHB_OFS_REC_NUM:   reg_rdata <= rec_num_q;
        `RHB_OFS_TS_RESETS: reg_rdata <= {16'h0, ts_resets_q};
        `RHB_OFS_GP_VEC:    reg_rdata <= {16'h0, gp_vec_q};
        `RHB_OFS_STATUS:    reg_rdata <= {24'h0, hdr_q.status};
        default:            reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
    begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Timestamp reset counter; wraps at 16 bits rather than saturating.
  // Software that needs more range must watch it for wrap itself.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ts_resets_q <= 16'h0000;
    end
    else if (ts_reset)
    begin
      ts_resets_q <= ts_resets_q + 16'h0001;
    end
  end

  // Record sequencing: wait for a start, capture until the end pulse, then
  // send the header. A start that arrives while busy is dropped without a
  // trace, so the engine must hold off until busy falls.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_q <= RHB_IDLE;
    end
    else
    begin
      case (state_q)
        RHB_IDLE:
        begin
          if (rec_start)
          begin
            state_q <= RHB_CAPTURE;
          end
        end
        RHB_CAPTURE:
        begin
          if (rec_end)
          begin
            state_q <= RHB_SEND;
          end
        end
        RHB_SEND:
        begin
          if (hdr_ready && last_byte)
          begin
            state_q <= RHB_IDLE;
          end
        end
        default:
        begin
          state_q <= RHB_IDLE;
        end
      endcase
    end
  end

  // The descriptor is taken only on an accepted start, so a start dropped
  // while busy cannot corrupt the record being sent.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rec_q <= '0;
    end
    else if (state_q == RHB_IDLE && rec_start)
    begin
      rec_q <= rec_info;
    end
  end

  // Over/under-range is sticky from the start edge to the end edge and is
  // reloaded at the next start, so one record never inherits another's.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      range_q <= 1'b0;
    end
    else if (state_q == RHB_IDLE && rec_start)
    begin
      range_q <= range_flag;
    end
    else if (state_q == RHB_CAPTURE)
    begin
      range_q <= range_q | range_flag;
    end
  end

  // Peak fill over the record; a long record reports its worst moment, not
  // the level at its end.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      fill_q <= 3'h0;
    end
    else if (state_q == RHB_IDLE && rec_start)
    begin
      fill_q <= fill_d;
    end
    else if (state_q == RHB_CAPTURE && fill_d > fill_q)
    begin
      fill_q <= fill_d;
    end
  end

  // Record number; the header carries the count before this record, so the
  // first record after reset is number zero. It wraps at 32 bits.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rec_num_q <= 32'h0000_0000;
    end
    else if (state_q == RHB_CAPTURE && rec_end)
    begin
      rec_num_q <= rec_num_q + 32'h0000_0001;
    end
  end

  // Byte pointer; it returns to zero after the last byte so that hdr_data
  // never indexes past the end of the header between records.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      idx_q <= 6'h00;
    end
    else if (state_q == RHB_SEND && hdr_ready)
    begin
      if (last_byte)
      begin
        idx_q <= 6'h00;
      end
      else
      begin
        idx_q <= idx_q + 6'd1;
      end
    end
  end

  // Header snapshot taken on the end edge; it stays put while the host
  // stalls, and the status byte stays readable until the next record ends.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      hdr_q <= '0;
    end
    else if (state_q == RHB_CAPTURE && rec_end)
    begin
      hdr_q.status       <= status_d;
      hdr_q.user_id      <= uhe_q ? user_id_q : 8'h00;
      hdr_q.channel      <= rec_q.channel;
      hdr_q.fmt          <= fmt32_q ? `RHB_FMT_32 : `RHB_FMT_16;
      hdr_q.serial       <= serial_q;
      hdr_q.rec_num      <= rec_num_q;
      hdr_q.period       <= period_q;
      hdr_q.trig_time    <= rec_q.trig_time;
      hdr_q.start_offset <= rec_q.start_offset;
      hdr_q.length       <= rec_q.length;
      hdr_q.gp_vec       <= gp_vec_q;
      hdr_q.ts_resets    <= ts_resets_q;
    end
  end

  // Byte k of the header is bits [8k+7:8k] of the packed header, status
  // at byte 0 and each multi-byte field low byte first.
  always_comb
  begin
    hdr_bits = hdr_q;
  end

  // Handshake outputs come straight from the state so that valid rises
  // the cycle after the end edge with no extra pipeline stage.
  always_comb
  begin
    last_byte = (idx_q == `RHB_HDR_BYTES - 6'd1);
    hdr_valid = (state_q == RHB_SEND);
    hdr_last  = hdr_valid && last_byte;
    busy      = (state_q != RHB_IDLE);
  end

  // The byte mux is fed from the header flops only, so the data stays
  // steady for as long as the host holds ready low.
  always_comb
  begin
    hdr_data = hdr_bits[{idx_q, 3'h0} +: 8];
  end

endmodule : rhb_builder

// ==== hw/rhb_pkg.sv ====
/*
  Types shared by the record header builder: record descriptor, header
  layout and builder states. Assumes nothing of its surroundings.
*/
package rhb_pkg;

  // Per-record facts collected by the acquisition engine.
  typedef struct packed {
    logic [7:0]  channel;
    logic [63:0] trig_time;
    logic [63:0] start_offset;
    logic [31:0] length;
  } rhb_rec_t;

  // Loss report delivered with the end of a record.
  typedef struct packed {
    logic lost_end;
    logic lost_mid;
    logic lost_beg;
    logic lost_all;
  } rhb_loss_t;

  // Whole header, fields in reverse order of sending, least significant byte first.
  typedef struct packed {
    logic [15:0] ts_resets;
    logic [15:0] gp_vec;
    logic [31:0] length;
    logic [63:0] start_offset;
    logic [63:0] trig_time;
    logic [31:0] period;
    logic [31:0] rec_num;
    logic [31:0] serial;
    logic [7:0]  fmt;
    logic [7:0]  channel;
    logic [7:0]  user_id;
    logic [7:0]  status;
  } rhb_hdr_t;

  typedef enum logic [1:0] {
    RHB_IDLE,
    RHB_CAPTURE,
    RHB_SEND
  } rhb_state_t;

endpackage : rhb_pkg

// ==== hw/rhb_regs.svh ====
/*
  Offsets, field positions, reset values and the header size for the record
  header builder. Assumes inclusion by bare name from a design file.
*/
`ifndef RHB_REGS_SVH
`define RHB_REGS_SVH

// Register offsets (word addresses on the plain register port).
`define RHB_OFS_CTRL      4'h0
`define RHB_OFS_USER_ID   4'h1
`define RHB_OFS_SERIAL    4'h2
`define RHB_OFS_PERIOD    4'h3
`define RHB_OFS_REC_NUM   4'h4
`define RHB_OFS_TS_RESETS 4'h5
`define RHB_OFS_GP_VEC    4'h6
`define RHB_OFS_STATUS    4'h7

// Control register fields.
`define RHB_CTRL_FMT_BIT  0
`define RHB_CTRL_UHE_BIT  1

// Status byte field positions.
`define RHB_ST_RANGE_BIT  7
`define RHB_ST_FILL_HI    6
`define RHB_ST_FILL_LO    4
`define RHB_ST_LOST_END   3
`define RHB_ST_LOST_MID   2
`define RHB_ST_LOST_BEG   1
`define RHB_ST_LOST_ALL   0

// Header size in bytes and in emitted bytes count width.
`define RHB_HDR_BYTES     6'd40

// Reset values.
`define RHB_RST_SERIAL    32'h0000_0000
`define RHB_RST_PERIOD    32'h0000_0008
`define RHB_RST_USER_ID   8'h00

// Data format codes.
`define RHB_FMT_16        8'h00
`define RHB_FMT_32        8'h01

`endif

// ==== tb/record_header_builder_tb.sv ====
/* Bench for the record header builder: a table of records, then odd cases.
   Assumes the host sink model and the bound checker. */
`timescale 1ns/10ps
`include "rhb_regs.svh"
`define CHK(a, e) \
  begin \
    check_count++; \
    if ((a) !== (e)) \
    begin \
      err_count++; \
      $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); \
    end \
  end
module record_header_builder_tb
  import rhb_pkg::*;
  ;
  typedef struct packed {
    logic [7:0]  ch;
    logic        fmt;
    logic        uhe;
    logic        rng;
    logic [15:0] peak;
    logic [3:0]  loss;
    logic        slow;
    logic [7:0]  st;
  } rhb_row_t;
  localparam rhb_row_t ROWS [5] = '{
    '{8'h00, 1'b0, 1'b1, 1'b0, 16'h0000, 4'h0, 1'b0, 8'h00},
    '{8'h01, 1'b1, 1'b1, 1'b1, 16'h0030, 4'h1, 1'b1, 8'hB1},
    '{8'h02, 1'b0, 1'b0, 1'b0, 16'h007F, 4'h2, 1'b0, 8'h72},
    '{8'h03, 1'b1, 1'b1, 1'b1, 16'h0050, 4'h4, 1'b1, 8'hD4},
    '{8'hFE, 1'b0, 1'b1, 1'b0, 16'h0010, 4'h8, 1'b0, 8'h18}};
  localparam logic [63:0] TT  = 64'h0123_4567_89AB_CDEF;
  localparam logic [63:0] OFS = 64'hFFFF_FFFF_FFFF_FF80;
  localparam logic [31:0] LEN = 32'h0000_0800;

  logic        clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic        rec_start = 1'b0, rec_end = 1'b0, range_flag = 1'b0;
  rhb_rec_t    rec_info = '0;
  rhb_loss_t   rec_loss = '0;
  logic [15:0] fifo_level = 16'h0000, fifo_depth = 16'h0080;
  logic        ts_reset = 1'b0, slow = 1'b0;
  logic [7:0]  hdr_data, got [40];
  logic        hdr_valid, hdr_last, hdr_ready, busy;
  logic [319:0] e;
  rhb_row_t    r;
  int          err_count = 0, check_count = 0;

  rhb_builder #(.FILL_W(16)) i_dut (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rec_start(rec_start),
    .rec_info(rec_info), .rec_end(rec_end), .rec_loss(rec_loss),
    .range_flag(range_flag), .fifo_level(fifo_level),
    .fifo_depth(fifo_depth), .ts_reset(ts_reset), .hdr_data(hdr_data),
    .hdr_valid(hdr_valid), .hdr_last(hdr_last), .hdr_ready(hdr_ready),
    .busy(busy));
  rhb_host_sink i_sink (.clk(clk), .hdr_data(hdr_data),
    .hdr_valid(hdr_valid), .hdr_last(hdr_last), .hdr_ready(hdr_ready),
    .slow(slow), .got(got));

  // Free-running 10 MHz clock.
  always #50 clk = ~clk;

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    `CHK(reg_rdata, x);
  endtask : rd

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // Watchdog sized well above the few hundred cycles the whole sequence takes.
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    test_done();
  end

  // Main sequence: reset values, the record table, then odd accesses.
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    `CHK(busy, 1'b0);
    `CHK(hdr_valid, 1'b0);
    rd(`RHB_OFS_PERIOD, 32'h0000_0008);
    rd(4'h8, 32'h0);
    $display("reset test done");
    wr(`RHB_OFS_SERIAL, 32'h0000_0FA5);
    wr(`RHB_OFS_PERIOD, 32'h0000_0010);
    wr(`RHB_OFS_USER_ID, 32'h0000_005A);
    wr(`RHB_OFS_GP_VEC, 32'h0000_BEEF);
    repeat (2)
    begin
      @(posedge clk);
      ts_reset <= 1'b1;
      @(posedge clk);
      ts_reset <= 1'b0;
    end
    rd(`RHB_OFS_TS_RESETS, 32'h2);
    for (int i = 0; i < 5; i++)
    begin
      r = ROWS[i];
      slow <= r.slow;
      wr(`RHB_OFS_CTRL, {30'h0, r.uhe, r.fmt});
      @(posedge clk);
      rec_start <= 1'b1;
      rec_info  <= '{r.ch, TT, OFS, LEN};
      @(posedge clk);
      rec_start  <= 1'b0;
      range_flag <= r.rng;
      fifo_level <= r.peak;
      @(posedge clk);
      range_flag <= 1'b0;
      fifo_level <= 16'h0008;
      rec_end    <= 1'b1;
      rec_loss   <= r.loss;
      @(posedge clk);
      rec_end <= 1'b0;
      for (int n = 0; n < 200 && busy !== 1'b0; n++)
        @(negedge clk);
      `CHK(busy, 1'b0);
      e = {16'h0002, 16'hBEEF, LEN, OFS, TT, 32'h0000_0010, 32'(i),
           32'h0000_0FA5, 7'h00, r.fmt, r.ch, r.uhe ? 8'h5A : 8'h00, r.st};
      for (int b = 0; b < 40; b++)
        `CHK(got[b], e[b*8 +: 8]);
      rd(`RHB_OFS_STATUS, {24'h0, r.st});
      rd(`RHB_OFS_REC_NUM, i + 1);
      $display("record %0d test done", i);
    end
    wr(`RHB_OFS_REC_NUM, 32'h0000_00FF);
    rd(`RHB_OFS_REC_NUM, 32'h5);
    $display("read-only test done");
    // Reset in mid-capture: nothing may be sent and the count restarts.
    @(posedge clk);
    rec_start <= 1'b1;
    @(posedge clk);
    rec_start <= 1'b0;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    `CHK(busy, 1'b0);
    `CHK(hdr_valid, 1'b0);
    rd(`RHB_OFS_REC_NUM, 32'h0);
    rd(`RHB_OFS_PERIOD, 32'h0000_0008);
    $display("mid-run reset test done");
    test_done();
  end
endmodule : record_header_builder_tb

// ==== tb/rhb_builder_chk.sv ====
/* Port checker for the record header builder.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/10ps
module rhb_builder_chk
  import rhb_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // Record side
  input wire logic       rec_start,
  input wire logic       rec_end,
  input wire rhb_loss_t  rec_loss,
  input wire logic       range_flag,
  // Header stream
  input wire logic [7:0] hdr_data,
  input wire logic       hdr_valid,
  input wire logic       hdr_last,
  input wire logic       hdr_ready,
  input wire logic       busy
);
  logic       cap_q;
  logic       rng_q;
  logic [3:0] loss_q;
  logic [5:0] cnt_q;
  wire        acc = hdr_valid && hdr_ready;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Shadow of the capture window, so the status byte can be predicted.
  always_ff @(posedge clk)
  begin
    if (!rstn)
      cap_q <= 1'b0;
    else if (rec_start && !busy)
      cap_q <= 1'b1;
    else if (rec_end && cap_q)
      cap_q <= 1'b0;
  end

  // Range is sticky across the whole window, end edge included.
  always_ff @(posedge clk)
  begin
    if (rec_start && !busy)
      rng_q <= range_flag;
    else if (cap_q)
      rng_q <= rng_q | range_flag;
    if (rec_end && cap_q)
      loss_q <= rec_loss;
  end

  // Counts accepted bytes; a stall must not advance it.
  always_ff @(posedge clk)
  begin
    if (!rstn || (acc && hdr_last))
      cnt_q <= 6'h00;
    else if (acc)
      cnt_q <= cnt_q + 6'h01;
  end

  sequence s_end_taken;
    rec_end && cap_q;
  endsequence
  sequence s_frame_out;
    acc && hdr_last;
  endsequence

  a_header_start: assert property (s_end_taken |=> hdr_valid ##0 cnt_q == 0)
    else $error("header late");
  a_byte_hold: assert property (hdr_valid && !hdr_ready |=> hdr_valid && $stable(hdr_data))
    else $error("byte moved");
  a_last_pos: assert property (hdr_valid |-> hdr_last == (cnt_q == 6'h27))
    else $error("bad length");
  a_frame_close: assert property (s_frame_out |=> !hdr_valid && !busy)
    else $error("no close");
  a_range_bit: assert property (hdr_valid && cnt_q == 0 |-> hdr_data[7] == rng_q)
    else $error("range bit");
  a_loss_bits: assert property (hdr_valid && cnt_q == 0 |-> hdr_data[3:0] == loss_q)
    else $error("loss bits");
  a_fmt_code: assert property (hdr_valid && cnt_q == 6'h03 |-> hdr_data[7:1] == 7'h00)
    else $error("format code");
  a_start_busy: assert property (rec_start && !busy |=> busy [*2])
    else $error("start lost");
endmodule : rhb_builder_chk

bind rhb_builder rhb_builder_chk i_chk (.clk, .rstn, .rec_start, .rec_end,
  .rec_loss, .range_flag, .hdr_data, .hdr_valid, .hdr_last, .hdr_ready,
  .busy);

// ==== tb/rhb_host_sink.sv ====
/* Host side model: accepts header bytes, optionally stalling.
   Assumes the builder's valid/ready byte stream. */
`timescale 1ns/10ps
module rhb_host_sink (
  // Stream
  input  wire logic       clk,
  input  wire logic [7:0] hdr_data,
  input  wire logic       hdr_valid,
  input  wire logic       hdr_last,
  output logic            hdr_ready,
  // Control and capture
  input  wire logic       slow,
  output logic [7:0]      got [40]
);
  int   n_q  = 0;
  logic ph_q = 1'b0;

  // A slow host refuses every other cycle, which exercises the hold path.
  assign hdr_ready = slow ? ph_q : 1'b1;

  // A header alone is a whole delivery; no sample data must follow it.
  always @(posedge clk)
  begin
    ph_q <= ~ph_q;
    if (hdr_valid && hdr_ready)
    begin
      got[n_q] <= hdr_data;
      n_q      <= hdr_last ? 0 : n_q + 1;
    end
  end
endmodule : rhb_host_sink
